// File: core/mpm_defines.svh
// Offsets, field positions, reset values and timing counts of the management block
`ifndef MPM_DEFINES_SVH
`define MPM_DEFINES_SVH

// Two-wire slave address of the management map
`define MPM_DEV_ADDR 7'h50

// Byte offsets of the management map
`define MPM_OFS_STATUS 3'h0
`define MPM_OFS_FLAGS 3'h1
`define MPM_OFS_CTRL 3'h2
`define MPM_OFS_MASK 3'h3
`define MPM_OFS_MON0 3'h4

// Field positions in the status byte
`define MPM_BIT_NOT_READY 0
`define MPM_BIT_ATTN 1
`define MPM_BIT_LOW_POWER 2

// Field positions in the flag and control bytes
`define MPM_BIT_RST_DONE 4
`define MPM_BIT_FORCE_LP 4

// Reset values of the writable bytes
`define MPM_CTRL_RST 8'h00
`define MPM_MASK_RST 8'h00

// Clock rate and timing
`define MPM_CLK_MHZ 100
`define MPM_RESET_MIN_NS 2000
`define MPM_INIT_NS 1000
// Least time rounds up
`define MPM_RESET_MIN_CYC ((`MPM_RESET_MIN_NS * `MPM_CLK_MHZ + 999) / 1000)
// Longest time rounds down
`define MPM_INIT_CYC ((`MPM_INIT_NS * `MPM_CLK_MHZ) / 1000)

`endif

// File: core/mpm_pkg.sv
// Types shared by the management block and its bench
package mpm_pkg;

  // Two-wire bus slave states
  typedef enum logic [2:0] {
    MPM_BUS_IDLE,
    MPM_BUS_ADDR,
    MPM_BUS_WRITE,
    MPM_BUS_ACK,
    MPM_BUS_READ,
    MPM_BUS_RACK
  } mpm_bus_st_t;

  // Module life cycle after power-up or pin reset
  typedef enum logic [1:0] {
    MPM_LIFE_INIT,
    MPM_LIFE_RUN,
    MPM_LIFE_RESET
  } mpm_life_t;

  // Per-lane receive information from the optical front end
  typedef struct packed {
    logic [3:0] below;
    logic [3:0][7:0] level;
  } mpm_lane_mon_t;

  // Whole state of the block
  typedef struct packed {
    mpm_bus_st_t st;
    mpm_life_t life;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic rw;
    logic ptr_set;
    logic [2:0] ptr;
    logic sda_oe;
    logic [11:0] rst_cnt;
    logic [11:0] init_cnt;
    logic not_ready;
    logic rst_done;
    logic [3:0] los_flags;
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic [3:0] tx_off;
    logic low_power;
    logic rx_lost;
    logic attn_oe;
    logic present_n;
  } mpm_state_t;

endpackage : mpm_pkg

// File: core/mpm_top.sv
// Management pin logic of a four-lane pluggable transceiver with two-wire slave
`timescale 1ns/1ps
`include "mpm_defines.svh"

module mpm_top
  import mpm_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Two-wire serial management bus
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Host control pins
  input wire logic MODULE_SELECT_N,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_SELECT,
  input wire logic TRANSMIT_DISABLE,
  // Host status pins
  output logic PRESENCE_N,
  output logic ATTENTION_N_OUT,
  output logic ATTENTION_N_OE,
  // Optical front end
  input wire mpm_lane_mon_t LANE_MON,
  output logic [3:0] TRANSMIT_OFF,
  output logic POWER_LIMIT,
  output logic RECEIVE_SIGNAL_LOST
);

  localparam logic [11:0] RESET_MIN = 12'(`MPM_RESET_MIN_CYC);
  localparam logic [11:0] INIT_LAST = 12'(`MPM_INIT_CYC - 1);

  mpm_state_t s_reg;
  mpm_state_t s_next;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic rd_en;
  logic wr_en;
  logic [7:0] rd_data;

  // Map readout; monitored lane levels are read live so the host sees current values
  function automatic logic [7:0] mpm_rd_byte(
    input logic [2:0] a,
    input mpm_state_t st,
    input mpm_lane_mon_t m
  );
    logic [7:0] b;
    b = 8'h00;
    case (a)
      `MPM_OFS_STATUS: begin
        b[`MPM_BIT_NOT_READY] = st.not_ready;
        b[`MPM_BIT_ATTN] = st.attn_oe;
        b[`MPM_BIT_LOW_POWER] = st.low_power;
      end
      `MPM_OFS_FLAGS: begin
        b[3:0] = st.los_flags;
        b[`MPM_BIT_RST_DONE] = st.rst_done;
      end
      `MPM_OFS_CTRL: begin
        b = st.ctrl;
      end
      `MPM_OFS_MASK: begin
        b = st.mask;
      end
      default: begin
        b = m.level[2'(a - `MPM_OFS_MON0)];
      end
    endcase
    return b;
  endfunction : mpm_rd_byte

  // Edge and framing detection on the sampled bus lines
  assign scl_rise = ~s_reg.scl_q & SCL_IN;
  assign scl_fall = s_reg.scl_q & ~SCL_IN;
  assign bus_start = s_reg.scl_q & SCL_IN & s_reg.sda_q & ~SDA_IN;
  assign bus_stop = s_reg.scl_q & SCL_IN & ~s_reg.sda_q & SDA_IN;
  assign rd_data = mpm_rd_byte(s_reg.ptr, s_reg, LANE_MON);

  // Next-state logic for bus slave, life cycle, flags and pins
  always_comb begin
    s_next = s_reg;
    rd_en = 1'b0;
    wr_en = 1'b0;
    s_next.scl_q = SCL_IN;
    s_next.sda_q = SDA_IN;

    // Two-wire slave; deselected or in reset it drops any transfer in flight
    if (MODULE_SELECT_N || s_reg.life == MPM_LIFE_RESET) begin
      s_next.st = MPM_BUS_IDLE;
      s_next.sda_oe = 1'b0;
    end else if (bus_start) begin
      s_next.st = MPM_BUS_ADDR;
      s_next.cnt = 4'h0;
      s_next.sda_oe = 1'b0;
    end else if (bus_stop) begin
      s_next.st = MPM_BUS_IDLE;
      s_next.sda_oe = 1'b0;
    end else begin
      case (s_reg.st)
        MPM_BUS_IDLE: begin
          s_next.sda_oe = 1'b0;
        end
        MPM_BUS_ADDR, MPM_BUS_WRITE: begin
          if (scl_rise) begin
            s_next.shreg = {s_reg.shreg[6:0], SDA_IN};
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (scl_fall && s_reg.cnt == 4'h8) begin
            if (s_reg.st == MPM_BUS_ADDR) begin
              // Foreign address: stay silent until the next start
              if (s_reg.shreg[7:1] == `MPM_DEV_ADDR) begin
                s_next.rw = s_reg.shreg[0];
                s_next.ptr_set = s_reg.shreg[0] ? s_reg.ptr_set : 1'b0;
                s_next.sda_oe = 1'b1;
                s_next.st = MPM_BUS_ACK;
              end else begin
                s_next.st = MPM_BUS_IDLE;
              end
            end else begin
              // First written byte is the pointer, later ones are data
              if (!s_reg.ptr_set) begin
                s_next.ptr = s_reg.shreg[2:0];
                s_next.ptr_set = 1'b1;
              end else begin
                wr_en = 1'b1;
                s_next.ptr = s_reg.ptr + 3'h1;
              end
              s_next.sda_oe = 1'b1;
              s_next.st = MPM_BUS_ACK;
            end
          end
        end
        MPM_BUS_ACK: begin
          // Acknowledge held through one low and one high clock phase, until the next falling edge
          if (scl_fall) begin
            s_next.cnt = 4'h0;
            if (s_reg.rw) begin
              rd_en = 1'b1;
              s_next.shreg = rd_data;
              s_next.ptr = s_reg.ptr + 3'h1;
              s_next.sda_oe = ~rd_data[7];
              s_next.st = MPM_BUS_READ;
            end else begin
              s_next.sda_oe = 1'b0;
              s_next.st = MPM_BUS_WRITE;
            end
          end
        end
        MPM_BUS_READ: begin
          // Data bits change only while the clock is low
          if (scl_rise) begin
            s_next.cnt = s_reg.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_reg.cnt == 4'h8) begin
              s_next.sda_oe = 1'b0;
              s_next.st = MPM_BUS_RACK;
            end else begin
              s_next.shreg = {s_reg.shreg[6:0], 1'b0};
              s_next.sda_oe = ~s_reg.shreg[6];
            end
          end
        end
        MPM_BUS_RACK: begin
          // Host acknowledge asks for another byte, a nack ends the read
          if (scl_rise) begin
            s_next.st = SDA_IN ? MPM_BUS_IDLE : MPM_BUS_ACK;
          end
        end
        default: begin
          s_next.st = MPM_BUS_IDLE;
          s_next.sda_oe = 1'b0;
        end
      endcase
    end

    // Software writes reach only the control and mask bytes
    if (wr_en) begin
      if (s_reg.ptr == `MPM_OFS_CTRL) begin
        s_next.ctrl = s_reg.shreg;
      end
      if (s_reg.ptr == `MPM_OFS_MASK) begin
        s_next.mask = s_reg.shreg;
      end
    end

    // Latched flags clear on read; a new event in that cycle still sets
    if (rd_en && s_reg.ptr == `MPM_OFS_FLAGS) begin
      s_next.los_flags = 4'h0;
      s_next.rst_done = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      if (LANE_MON.below[i] && s_reg.life == MPM_LIFE_RUN) begin
        s_next.los_flags[i] = 1'b1;
      end
    end

    // Life cycle; power-up starts here too, so completion needs no pin reset
    case (s_reg.life)
      MPM_LIFE_INIT: begin
        if (s_reg.init_cnt >= INIT_LAST) begin
          s_next.life = MPM_LIFE_RUN;
          s_next.not_ready = 1'b0;
          s_next.rst_done = 1'b1;
        end else begin
          s_next.init_cnt = s_reg.init_cnt + 12'h001;
        end
      end
      MPM_LIFE_RUN: begin
        s_next.init_cnt = 12'h000;
      end
      MPM_LIFE_RESET: begin
        // Initialisation begins when the reset pin is released
        if (MODULE_RESET_N) begin
          s_next.life = MPM_LIFE_INIT;
          s_next.init_cnt = 12'h000;
        end
      end
      default: begin
        s_next.life = MPM_LIFE_INIT;
      end
    endcase

    // Reset pin filter: only a low lasting beyond the minimum resets
    if (!MODULE_RESET_N) begin
      if (s_reg.rst_cnt >= RESET_MIN) begin
        s_next.life = MPM_LIFE_RESET;
        s_next.not_ready = 1'b1;
        s_next.rst_done = 1'b0;
        s_next.los_flags = 4'h0;
        s_next.ctrl = `MPM_CTRL_RST;
        s_next.mask = `MPM_MASK_RST;
        s_next.ptr = 3'h0;
        s_next.ptr_set = 1'b0;
        s_next.init_cnt = 12'h000;
      end else begin
        s_next.rst_cnt = s_reg.rst_cnt + 12'h001;
      end
    end else begin
      s_next.rst_cnt = 12'h000;
    end

    // Attention pulls low while any unmasked latched flag is pending
    s_next.attn_oe = s_next.rst_done | |(s_next.los_flags & ~s_next.mask[3:0]);
    if (s_next.life == MPM_LIFE_RESET) begin
      s_next.attn_oe = 1'b0;
    end

    // Pin outputs; a lane transmitter is dark if either disable source asks
    for (int i = 0; i < 4; i++) begin
      s_next.tx_off[i] = TRANSMIT_DISABLE | s_next.ctrl[i];
    end
    s_next.low_power = LOW_POWER_SELECT | s_next.ctrl[`MPM_BIT_FORCE_LP];
    s_next.rx_lost = |LANE_MON.below;
    s_next.present_n = 1'b0;
  end

  // State register; reset leaves the module in initialisation, not ready
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      s_reg <= '0;
      s_reg.not_ready <= 1'b1;
      s_reg.scl_q <= 1'b1;
      s_reg.sda_q <= 1'b1;
      s_reg.tx_off <= 4'hF;
    end else begin
      s_reg <= s_next;
    end
  end

  // Open-drain lines only ever pull low; the host board provides the pull-up
  assign SDA_OUT = 1'b0;
  assign SDA_OE = s_reg.sda_oe;
  assign ATTENTION_N_OUT = 1'b0;
  assign ATTENTION_N_OE = s_reg.attn_oe;
  assign PRESENCE_N = s_reg.present_n;
  assign TRANSMIT_OFF = s_reg.tx_off;
  assign POWER_LIMIT = s_reg.low_power;
  assign RECEIVE_SIGNAL_LOST = s_reg.rx_lost;

endmodule : mpm_top

// File: tb/mpm_top_props.sv
// Concurrent checks on the management pin block
`timescale 1ns/1ps
`include "mpm_defines.svh"
module mpm_top_props
  import mpm_pkg::*;
(
  // Clock, reset, host and front-end inputs
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic MODULE_SELECT_N,
  input wire logic MODULE_RESET_N,
  input wire logic LOW_POWER_SELECT,
  input wire logic TRANSMIT_DISABLE,
  input wire mpm_lane_mon_t LANE_MON,
  // Watched outputs
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic PRESENCE_N,
  input wire logic ATTENTION_N_OUT,
  input wire logic ATTENTION_N_OE,
  input wire logic [3:0] TRANSMIT_OFF,
  input wire logic POWER_LIMIT,
  input wire logic RECEIVE_SIGNAL_LOST
);
  logic [7:0] up_reg;
  logic [8:0] lo_reg;
  // Saturating counts: cycles since reset release, consecutive low reset pin samples
  always_ff @(posedge SYS_CLK) begin
    up_reg <= !RSTN ? 8'h00 : up_reg + {7'h00, up_reg != 8'hFF};
    lo_reg <= (!RSTN || MODULE_RESET_N) ? 9'h000 : lo_reg + {8'h00, lo_reg != 9'h1FF};
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  sel_idle_a: assert property (MODULE_SELECT_N && $past(MODULE_SELECT_N) |-> !SDA_OE)
    else $error("data line held while deselected");
  presence_low_a: assert property (PRESENCE_N == 1'b0)
    else $error("presence not at ground");
  sda_drive_a: assert property (SDA_OUT == 1'b0)
    else $error("data line driven high");
  attn_drive_a: assert property (ATTENTION_N_OUT == 1'b0)
    else $error("attention driven high");
  tx_off_a: assert property ($past(TRANSMIT_DISABLE) |-> TRANSMIT_OFF == 4'hF)
    else $error("transmitter on while disabled");
  rx_lost_a: assert property ($past(RSTN) |-> RECEIVE_SIGNAL_LOST == |$past(LANE_MON.below))
    else $error("lost alarm wrong");
  low_power_a: assert property ($past(RSTN) && $past(LOW_POWER_SELECT) |-> POWER_LIMIT)
    else $error("power limit missing");
  // Reset fires on the low sample after the minimum count, attention drops with it
  pin_reset_a: assert property (lo_reg > 9'(`MPM_RESET_MIN_CYC) |-> !ATTENTION_N_OE)
    else $error("attention held in pin reset");
  // Completion lands exactly one initialisation period after reset release
  init_quiet_a: assert property (up_reg < 8'(`MPM_INIT_CYC) |-> !ATTENTION_N_OE)
    else $error("attention before ready");
  init_post_a: assert property (up_reg == 8'(`MPM_INIT_CYC) |-> ATTENTION_N_OE)
    else $error("no power-up completion");
endmodule : mpm_top_props

bind mpm_top mpm_top_props props_u (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
  .MODULE_SELECT_N(MODULE_SELECT_N), .MODULE_RESET_N(MODULE_RESET_N),
  .LOW_POWER_SELECT(LOW_POWER_SELECT), .TRANSMIT_DISABLE(TRANSMIT_DISABLE),
  .LANE_MON(LANE_MON), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .PRESENCE_N(PRESENCE_N),
  .ATTENTION_N_OUT(ATTENTION_N_OUT), .ATTENTION_N_OE(ATTENTION_N_OE),
  .TRANSMIT_OFF(TRANSMIT_OFF), .POWER_LIMIT(POWER_LIMIT),
  .RECEIVE_SIGNAL_LOST(RECEIVE_SIGNAL_LOST));

// File: tb/mpm_host.sv
// Host two-wire master model driving the management bus
`timescale 1ns/1ps
module mpm_host (
  // Clock
  input wire logic clk,
  // Two-wire bus
  input wire logic sda_in,
  output logic scl,
  output logic sda_oe
);
  // Bus idles with clock high and data released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // One phase: change after an edge, hold four cycles so the slave sees stable levels
  task automatic step(input logic c, input logic d);
    @(posedge clk);
    scl <= c;
    sda_oe <= !d;
    repeat (3) @(posedge clk);
  endtask : step
  // Start or repeated start
  task automatic start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start
  // Stop ends the frame with clock left high
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop
  // Byte MSB first, then the ninth bit; all ones releases data for a read
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
    output logic ack);
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, tx[i]);
      step(1'b1, tx[i]);
      rx[i] = sda_in;
      step(1'b0, tx[i]);
    end
    step(1'b0, mack);
    step(1'b1, mack);
    ack = !sda_in;
    step(1'b0, mack);
  endtask : xfer
endmodule : mpm_host

// File: tb/tb_mpm_top.sv
// Self-checking bench for the management pin block
`timescale 1ns/1ps
`include "mpm_defines.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb_mpm_top
  import mpm_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sel_n = 1'b0;
  logic mrst_n = 1'b1;
  logic lps = 1'b0;
  logic txdis = 1'b0;
  mpm_lane_mon_t mon = '0;
  logic sda_oe, attn_oe, pres_n, rx_lost, plim, scl, h_oe, a;
  logic [3:0] tx_off;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  wire sda = !(sda_oe || h_oe); // Pull-up unless someone pulls low
  always #5 clk = !clk;
  mpm_top dut_u (.SYS_CLK(clk), .RSTN(rstn), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(),
    .SDA_OE(sda_oe), .MODULE_SELECT_N(sel_n), .MODULE_RESET_N(mrst_n),
    .LOW_POWER_SELECT(lps), .TRANSMIT_DISABLE(txdis), .PRESENCE_N(pres_n),
    .ATTENTION_N_OUT(), .ATTENTION_N_OE(attn_oe), .LANE_MON(mon), .TRANSMIT_OFF(tx_off),
    .POWER_LIMIT(plim), .RECEIVE_SIGNAL_LOST(rx_lost));
  mpm_host host_u (.clk(clk), .sda_in(sda), .scl(scl), .sda_oe(h_oe));
  // Settle past the edge so register outputs are read after they update
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : ticks
  // Write one map byte; the address acknowledge comes back
  task automatic wr(input logic [2:0] p, input logic [7:0] d, output logic ak);
    logic [7:0] r;
    logic k;
    host_u.start();
    host_u.xfer({`MPM_DEV_ADDR, 1'b0}, 1'b1, r, ak);
    host_u.xfer({5'h00, p}, 1'b1, r, k);
    host_u.xfer(d, 1'b1, r, k);
    host_u.stop();
  endtask : wr
  // Set the pointer, repeated start, read one byte and nack it
  task automatic rchk(input string nm, input logic [2:0] p, input logic [7:0] e);
    logic [7:0] d;
    logic k;
    host_u.start();
    host_u.xfer({`MPM_DEV_ADDR, 1'b0}, 1'b1, d, k);
    host_u.xfer({5'h00, p}, 1'b1, d, k);
    host_u.start();
    host_u.xfer({`MPM_DEV_ADDR, 1'b1}, 1'b1, d, k);
    host_u.xfer(8'hFF, 1'b1, d, k);
    host_u.stop();
    `CHK(nm, e, d)
  endtask : rchk
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  // Hang guard; the whole run needs about 8300 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    ticks(90);
    `CHK("attn early", 1'b0, attn_oe)
    for (int i = 0; i < 40 && attn_oe !== 1'b1; i++) ticks(1);
    `CHK("attn power-up", 1'b1, attn_oe)
    `CHK("presence", 1'b0, pres_n)
    rchk("status", `MPM_OFS_STATUS, 8'h02);
    rchk("flags", `MPM_OFS_FLAGS, 8'h10);
    ticks(2);
    `CHK("attn cleared", 1'b0, attn_oe)
    @(posedge clk) sel_n <= 1'b1;
    wr(`MPM_OFS_CTRL, 8'h0F, a);
    `CHK("ack deselected", 1'b0, a)
    `CHK("tx deselected", 4'h0, tx_off)
    @(posedge clk) sel_n <= 1'b0;
    wr(`MPM_OFS_CTRL, 8'h05, a);
    `CHK("ack selected", 1'b1, a)
    for (int t = 0; t < 2; t++) begin
      @(posedge clk) txdis <= t[0];
      ticks(3);
      `CHK("tx off", t ? 4'hF : 4'h5, tx_off)
    end
    @(posedge clk) lps <= 1'b1;
    ticks(3);
    `CHK("power pin", 1'b1, plim)
    rchk("status power", `MPM_OFS_STATUS, 8'h04);
    @(posedge clk) txdis <= 1'b0;
    mon.level <= {8'h44, 8'h33, 8'h22, 8'h11};
    for (int i = 0; i < 4; i++) rchk("monitor", 3'h4 + i[2:0], 8'(8'h11 * (i + 1)));
    @(posedge clk) mon.below <= 4'h4;
    ticks(2);
    `CHK("rx lost", 1'b1, rx_lost)
    ticks(2);
    `CHK("attn lane", 1'b1, attn_oe)
    @(posedge clk) mon.below <= 4'h0;
    rchk("flags lane", `MPM_OFS_FLAGS, 8'h04);
    ticks(2);
    `CHK("attn released", 1'b0, attn_oe)
    // Masked lane still latches its flag but must not pull attention
    wr(`MPM_OFS_MASK, 8'h04, a);
    @(posedge clk) mon.below <= 4'h4;
    ticks(3);
    `CHK("attn masked", 1'b0, attn_oe)
    @(posedge clk) mon.below <= 4'h0;
    rchk("flags masked", `MPM_OFS_FLAGS, 8'h04);
    // Longest low pulse that must not reset, then one that must
    @(posedge clk) mrst_n <= 1'b0;
    ticks(199);
    @(posedge clk) mrst_n <= 1'b1;
    rchk("ctrl kept", `MPM_OFS_CTRL, 8'h05);
    @(posedge clk) mrst_n <= 1'b0;
    ticks(260);
    @(posedge clk) mrst_n <= 1'b1;
    for (int i = 0; i < 150 && attn_oe !== 1'b1; i++) ticks(1);
    `CHK("attn after reset", 1'b1, attn_oe)
    rchk("ctrl default", `MPM_OFS_CTRL, `MPM_CTRL_RST);
    rchk("mask default", `MPM_OFS_MASK, `MPM_MASK_RST);
    rchk("flags done", `MPM_OFS_FLAGS, 8'h10);
    // Pin released, then the software force bit alone must limit power
    @(posedge clk) lps <= 1'b0;
    ticks(3);
    `CHK("power released", 1'b0, plim)
    wr(`MPM_OFS_CTRL, 8'h10, a);
    ticks(2);
    `CHK("power forced", 1'b1, plim)
    final_report();
  end
endmodule : tb_mpm_top
